// [floppy_ctrl_pkg.sv]
// Constants for the floppy drive control register bank.
// Assumes a byte-wide host port addressed by the low bits of the legacy I/O map.
// Overview of operation
// - Drive output control clears on hardware reset only
// - Low two bits encode selected drive
// - Bit 2 low holds controller in reset
// - Back-to-back clear/set writes give valid reset
// - Bit 3 gates DMA and interrupt in legacy
// - Extended mode keeps DMA and interrupt enabled
// - Bits 4,5 drive active-low motor outputs
// - Select low only when motor bit and number match
// - Bits 6,7 drive no pin
// - Tape field selects tape drive, 0 accepted and reset value
// - Tape assignment survives software reset
// - Normal mode reads tape bits 7:2 zero
// - Enhanced mode reads drive type, boot drive
// - Drive type picked from config F2 pair
// - Rate select write-only, hardware reset 02
// - Latest rate write from either register wins
// - Bits 4:2 choose write precompensation delay
// - Precompensation starts at configurable track
// - Power-down bit stops clock until wake
// - Rate bit 7 resets controller, self-clearing
`default_nettype none
package floppy_ctrl_pkg;
  localparam logic [9:0] OFF_DRIVE_OUT  = 10'h3f2;
  localparam logic [9:0] OFF_TAPE       = 10'h3f3;
  localparam logic [9:0] OFF_RATE       = 10'h3f4;
  localparam logic [9:0] OFF_DATA       = 10'h3f5;
  localparam logic [9:0] OFF_CCR        = 10'h3f7;
  localparam logic [7:0] DRIVE_OUT_RST  = 8'h00;
  localparam logic [7:0] RATE_RST       = 8'h02;
  localparam logic [1:0] TAPE_RST       = 2'h0;
  localparam logic [7:0] WRITE_FIELD_A_TRACK_RST = 8'h00;
  localparam int         BIT_RESET_N    = 2;
  localparam int         BIT_DMA_GATE   = 3;
  localparam int         BIT_MOTOR0     = 4;
  localparam int         BIT_MOTOR1     = 5;
  localparam int         BIT_POWER_DOWN = 6;
  localparam int         BIT_SOFT_RESET = 7;
  // Minimum software reset width and its cycle count at 25 MHz
  localparam int         SOFT_RESET_MIN_NS = 100;
  localparam int         CLK_PERIOD_NS     = 40;
  localparam int         SOFT_RESET_CYCLES =
    (SOFT_RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Precompensation delay in units of the nominal 41.67 ns step
  localparam logic [2:0] WRITE_FIELD_A_DEFAULT_CODE = 3'h0;
  localparam logic [2:0] WRITE_FIELD_A_ZERO_CODE    = 3'h7;
  localparam logic [2:0] DEFAULT_STEPS_FAST   = 3'h1;
  localparam logic [2:0] DEFAULT_STEPS_SLOW   = 3'h3;
  localparam logic [1:0] RATE_500K = 2'h0;
  localparam logic [1:0] RATE_300K = 2'h1;
  localparam logic [1:0] RATE_250K = 2'h2;
  localparam logic [1:0] RATE_1M   = 2'h3;
  typedef enum logic [1:0] {MODE_LEGACY_AT, MODE_SLIM, MODE_EXTENDED} status_mode_t;
endpackage
`default_nettype wire

// [floppy_drive_control_regs.sv]
// Host-visible drive output, tape assignment and rate/precompensation registers.
// Assumes a one-cycle host port, inputs synchronous to clk_i, config F2 held outside.
//
// Added by the designer: strobed register access.
`default_nettype none
module floppy_drive_control_regs (
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire logic [9:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  output var  logic [7:0] rdata_o,
  input  wire logic [1:0] status_mode_i,
  input  wire logic       enhanced_floppy_mode_2_i,
  input  wire logic       swap_drives_i,
  input  wire logic [7:0] fdc_config_reg_f2_i,
  input  wire logic [1:0] boot_drive_i,
  input  wire logic       ccr_rate_wr_i,
  input  wire logic [1:0] ccr_rate_i,
  input  wire logic       write_field_a_track_wr_i,
  input  wire logic [7:0] write_field_a_track_i,
  output var  logic       select_out_drive0_n_o,
  output var  logic       select_out_drive1_n_o,
  output var  logic       motor_out_drive0_n_o,
  output var  logic       motor_out_drive1_n_o,
  output var  logic       dma_irq_gate_o,
  output var  logic       ctrl_reset_o,
  output var  logic       power_down_o,
  output var  logic [1:0] rate_field_o,
  output var  logic [2:0] write_field_a_o,
  output var  logic [2:0] write_field_a_steps_o,
  output var  logic [1:0] tape_drive_o,
  output var  logic [7:0] write_field_a_track_o
);
  logic [7:0] drive_output_control_reg;
  logic [1:0] tape_assignment_reg;
  logic [7:0] rate_write_field_a_select_reg;
  logic [1:0] active_rate_reg;
  logic [1:0] pulse_cnt_reg;
  logic       power_down_reg;
  logic       wr_dor;
  logic       wr_tape;
  logic       wr_rate;
  logic       soft_reset;
  logic       wake;
  logic       held_soft_reset_n;
  logic [1:0] sel;
  logic       sel_hit0;
  logic       sel_hit1;
  logic [7:0] tape_read;
  logic [1:0] drive_type;
  logic [2:0] pc_code;

  assign wr_dor  = wr_i && addr_i == floppy_ctrl_pkg::OFF_DRIVE_OUT;
  assign wr_tape = wr_i && addr_i == floppy_ctrl_pkg::OFF_TAPE;
  assign wr_rate = wr_i && addr_i == floppy_ctrl_pkg::OFF_RATE;
  assign held_soft_reset_n = drive_output_control_reg[floppy_ctrl_pkg::BIT_RESET_N];
  // Self-clearing reset is stretched so it always meets the minimum width
  assign soft_reset = !held_soft_reset_n || pulse_cnt_reg != 2'h0;
  // Host access to data or main status register leaves manual low power
  assign wake = (rd_i || wr_i) && (addr_i == floppy_ctrl_pkg::OFF_DATA
                || (rd_i && addr_i == floppy_ctrl_pkg::OFF_RATE));

  // Only hardware reset clears it; software reset never touches it
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      drive_output_control_reg <= floppy_ctrl_pkg::DRIVE_OUT_RST;
    end else if (wr_dor) begin
      drive_output_control_reg <= wdata_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      tape_assignment_reg <= floppy_ctrl_pkg::TAPE_RST;
    end else if (wr_tape) begin
      tape_assignment_reg <= wdata_i[1:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      rate_write_field_a_select_reg <= floppy_ctrl_pkg::RATE_RST;
    end else if (wr_rate) begin
      rate_write_field_a_select_reg <= {1'b0, wdata_i[6], 1'b0, wdata_i[4:0]};
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      active_rate_reg <= floppy_ctrl_pkg::RATE_RST[1:0];
    end else if (wr_rate) begin
      active_rate_reg <= wdata_i[1:0];
    end else if (ccr_rate_wr_i) begin
      active_rate_reg <= ccr_rate_i;
    end
  end

  // A held-reset write starts the same stretch, so a clear-then-set pair
  // of back-to-back writes still lasts the minimum reset width
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      pulse_cnt_reg <= 2'h0;
    end else if ((wr_rate && wdata_i[floppy_ctrl_pkg::BIT_SOFT_RESET])
                 || (wr_dor && !wdata_i[floppy_ctrl_pkg::BIT_RESET_N])) begin
      pulse_cnt_reg <= 2'(floppy_ctrl_pkg::SOFT_RESET_CYCLES);
    end else if (pulse_cnt_reg != 2'h0) begin
      pulse_cnt_reg <= pulse_cnt_reg - 2'h1;
    end
  end

  // A fresh power-down write wins over a same-cycle wake
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      power_down_reg <= 1'b0;
    end else if (wr_rate && wdata_i[floppy_ctrl_pkg::BIT_POWER_DOWN]) begin
      power_down_reg <= 1'b1;
    end else if (soft_reset || wake) begin
      power_down_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      write_field_a_track_o <= floppy_ctrl_pkg::WRITE_FIELD_A_TRACK_RST;
    end else if (write_field_a_track_wr_i) begin
      write_field_a_track_o <= write_field_a_track_i;
    end
  end

  assign sel = drive_output_control_reg[1:0];
  assign sel_hit0 = drive_output_control_reg[floppy_ctrl_pkg::BIT_MOTOR0] && sel == 2'h0;
  assign sel_hit1 = drive_output_control_reg[floppy_ctrl_pkg::BIT_MOTOR1] && sel == 2'h1;

  // Bits 6 and 7 are stored and read back but reach no pin
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      select_out_drive0_n_o <= 1'b1;
      select_out_drive1_n_o <= 1'b1;
      motor_out_drive0_n_o  <= 1'b1;
      motor_out_drive1_n_o  <= 1'b1;
    end else if (!swap_drives_i) begin
      select_out_drive0_n_o <= !sel_hit0;
      select_out_drive1_n_o <= !sel_hit1;
      motor_out_drive0_n_o  <= !drive_output_control_reg[floppy_ctrl_pkg::BIT_MOTOR0];
      motor_out_drive1_n_o  <= !drive_output_control_reg[floppy_ctrl_pkg::BIT_MOTOR1];
    end else begin
      select_out_drive0_n_o <= !sel_hit1;
      select_out_drive1_n_o <= !sel_hit0;
      motor_out_drive0_n_o  <= !drive_output_control_reg[floppy_ctrl_pkg::BIT_MOTOR1];
      motor_out_drive1_n_o  <= !drive_output_control_reg[floppy_ctrl_pkg::BIT_MOTOR0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      dma_irq_gate_o <= 1'b0;
    end else if (status_mode_i == 2'(floppy_ctrl_pkg::MODE_EXTENDED)) begin
      dma_irq_gate_o <= 1'b1;
    end else begin
      dma_irq_gate_o <= drive_output_control_reg[floppy_ctrl_pkg::BIT_DMA_GATE];
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      ctrl_reset_o <= 1'b1;
      power_down_o <= 1'b0;
    end else begin
      ctrl_reset_o <= soft_reset;
      power_down_o <= power_down_reg;
    end
  end

  // Delay in 41.67 ns steps; the consumer halves the step at 2 Mbps
  assign pc_code = rate_write_field_a_select_reg[4:2];
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      rate_field_o    <= floppy_ctrl_pkg::RATE_RST[1:0];
      write_field_a_o <= floppy_ctrl_pkg::RATE_RST[4:2];
      write_field_a_steps_o <= floppy_ctrl_pkg::DEFAULT_STEPS_SLOW;
      tape_drive_o    <= floppy_ctrl_pkg::TAPE_RST;
    end else begin
      rate_field_o    <= active_rate_reg;
      write_field_a_o <= pc_code;
      tape_drive_o    <= tape_assignment_reg;
      if (pc_code == floppy_ctrl_pkg::WRITE_FIELD_A_ZERO_CODE) begin
        write_field_a_steps_o <= 3'h0;
      end else if (pc_code != floppy_ctrl_pkg::WRITE_FIELD_A_DEFAULT_CODE) begin
        write_field_a_steps_o <= pc_code;
      end else if (active_rate_reg == floppy_ctrl_pkg::RATE_1M) begin
        write_field_a_steps_o <= floppy_ctrl_pkg::DEFAULT_STEPS_FAST;
      end else begin
        write_field_a_steps_o <= floppy_ctrl_pkg::DEFAULT_STEPS_SLOW;
      end
    end
  end

  always_comb begin
    case (sel)
      2'h0:    drive_type = fdc_config_reg_f2_i[1:0];
      2'h1:    drive_type = fdc_config_reg_f2_i[3:2];
      2'h2:    drive_type = fdc_config_reg_f2_i[5:4];
      default: drive_type = fdc_config_reg_f2_i[7:6];
    endcase
  end

  always_comb begin
    if (enhanced_floppy_mode_2_i) begin
      tape_read = {2'h0, drive_type, boot_drive_i, tape_assignment_reg};
    end else begin
      tape_read = {6'h00, tape_assignment_reg};
    end
  end

  // Rate register is write-only; unmapped or write-only reads return zero
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      rdata_o <= 8'h00;
    end else if (rd_i && addr_i == floppy_ctrl_pkg::OFF_DRIVE_OUT) begin
      rdata_o <= drive_output_control_reg;
    end else if (rd_i && addr_i == floppy_ctrl_pkg::OFF_TAPE) begin
      rdata_o <= tape_read;
    end else begin
      rdata_o <= 8'h00;
    end
  end
endmodule
`default_nettype wire

// [floppy_ctrl_assertions.sv]
// Checker for the drive control register bank.
// Assumes it is bound into the top module and sees its ports only.
`default_nettype none
module floppy_ctrl_checker (
  input wire logic       clk_i,
  input wire logic       rst_n_i,
  input wire logic [9:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic       wr_i,
  input wire logic       rd_i,
  input wire logic [7:0] rdata_o,
  input wire logic [1:0] status_mode_i,
  input wire logic       swap_drives_i,
  input wire logic       ccr_rate_wr_i,
  input wire logic       select_out_drive0_n_o,
  input wire logic       motor_out_drive0_n_o,
  input wire logic       motor_out_drive1_n_o,
  input wire logic       dma_irq_gate_o,
  input wire logic       ctrl_reset_o,
  input wire logic [1:0] rate_field_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  logic dw;
  logic rw;
  assign dw = wr_i && addr_i == floppy_ctrl_pkg::OFF_DRIVE_OUT;
  assign rw = wr_i && addr_i == floppy_ctrl_pkg::OFF_RATE;
  motor_norm_a: assert property (dw && !swap_drives_i ##1 !swap_drives_i
    |=> {motor_out_drive1_n_o, motor_out_drive0_n_o} == ~$past(wdata_i[5:4], 2))
    else $error("motor pins do not follow written bits");
  motor_swap_a: assert property (dw && swap_drives_i ##1 swap_drives_i
    |=> motor_out_drive0_n_o == !$past(wdata_i[5], 2)) else $error("swapped motor wrong");
  select_dec_a: assert property (dw && !swap_drives_i ##1 !swap_drives_i
    |=> select_out_drive0_n_o == !($past(wdata_i[4], 2) && $past(wdata_i[1:0], 2) == 2'h0))
    else $error("drive 0 select wrong");
  dma_gate_a: assert property (dw && status_mode_i != 2'h2 ##1 status_mode_i != 2'h2
    |=> dma_irq_gate_o == $past(wdata_i[3], 2)) else $error("dma gate wrong");
  ext_enable_a: assert property ($past(status_mode_i, 2) == 2'h2 &&
    $past(status_mode_i) == 2'h2 && $past(rst_n_i, 2) && $past(rst_n_i)
    |-> dma_irq_gate_o) else $error("extended mode gate off");
  held_reset_a: assert property (dw && !wdata_i[2] |-> ##2 ctrl_reset_o)
    else $error("held reset missing");
  toggle_width_a: assert property (dw && !wdata_i[2] |-> ##2 ctrl_reset_o[*3])
    else $error("held reset shorter than minimum width");
  self_clear_a: assert property (rw && wdata_i[7] |-> ##2 ctrl_reset_o[*3])
    else $error("rate reset pulse short");
  rate_wr_a: assert property (rw ##1 !ccr_rate_wr_i
    |=> rate_field_o == $past(wdata_i[1:0], 2)) else $error("rate field wrong");
  wo_read_a: assert property (rd_i && addr_i == floppy_ctrl_pkg::OFF_RATE
    |=> rdata_o == 8'h00) else $error("rate register readable");
  cover property (dw && swap_drives_i);
  cover property (rw && wdata_i[7]);
  cover property (ccr_rate_wr_i);
endmodule
bind floppy_drive_control_regs floppy_ctrl_checker u_chk (.*);
`default_nettype wire

// [floppy_drive_model.sv]
// Behavioural drive pair on the select and motor pins.
// Assumes active-low pins; spin-up time is a parameter.
`default_nettype none
module floppy_drive_model #(
  parameter int SPIN_CYCLES = 4
) (
  input  wire logic       clk_i,
  input  wire logic       select_out_drive0_n_i,
  input  wire logic       select_out_drive1_n_i,
  input  wire logic       motor_out_drive0_n_i,
  input  wire logic       motor_out_drive1_n_i,
  output var  logic [1:0] ready_o,
  output var  logic       two_sel_o
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt [2];
  logic [1:0] on;
  assign on = ~{motor_out_drive1_n_i, motor_out_drive0_n_i};
  // A drive only reports ready once its spindle is up to speed
  assign two_sel_o = !select_out_drive0_n_i && !select_out_drive1_n_i;
  always @(posedge clk_i) begin
    for (int i = 0; i < 2; i++) begin
      cnt[i] = on[i] ? cnt[i] + 1 : 0;
      ready_o[i] <= cnt[i] >= SPIN_CYCLES;
    end
  end
endmodule
`default_nettype wire

// [testbench.sv]
// Self-checking bench for the drive control register bank.
// Assumes the checker binds itself and a drive model sits on the pins.
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 0, rst_n_i = 0, wr_i = 0, rd_i = 0, swap_drives_i = 0;
  logic enhanced_floppy_mode_2_i = 0, ccr_rate_wr_i = 0, write_field_a_track_wr_i = 0;
  logic [9:0] addr_i = '0;
  logic [7:0] wdata_i = '0, fdc_config_reg_f2_i = '0, write_field_a_track_i = '0, rdata_o, rdv;
  logic [1:0] status_mode_i = '0, boot_drive_i = '0, ccr_rate_i = '0, rate_field_o;
  logic [1:0] tape_drive_o, rdy;
  logic [2:0] write_field_a_o, write_field_a_steps_o;
  logic [7:0] write_field_a_track_o;
  logic select_out_drive0_n_o, select_out_drive1_n_o, motor_out_drive0_n_o;
  logic motor_out_drive1_n_o, dma_irq_gate_o, ctrl_reset_o, power_down_o, two;
  int err_count = 0;
  int checks_done = 0;
  int drive_output_control, rs, act, pwr, tape_assignment, v;
  floppy_drive_control_regs u_dut (.*);
  floppy_drive_model #(.SPIN_CYCLES(4)) u_drv (.clk_i,
    .select_out_drive0_n_i(select_out_drive0_n_o), .select_out_drive1_n_i(select_out_drive1_n_o),
    .motor_out_drive0_n_i(motor_out_drive0_n_o), .motor_out_drive1_n_i(motor_out_drive1_n_o),
    .ready_o(rdy), .two_sel_o(two));
  always #20 clk_i = ~clk_i;
  task automatic chk(input string n, input logic [19:0] e, input logic [19:0] g);
    checks_done++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1;
    @(posedge clk_i);
    wr_i <= 0;
  endtask
  task automatic rd(input logic [9:0] a);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1;
    @(posedge clk_i);
    rd_i <= 0;
    #1 rdv = rdata_o;
  endtask
  task automatic settle;
    repeat (2) @(posedge clk_i);
    #1;
  endtask
  // Every pin but rdata_o and write_field_a_track_o predicted from the bench's own register copies
  task automatic outs;
    logic [1:0] ds;
    logic [1:0] mt;
    logic [2:0] w;
    ds = {drive_output_control[5] && drive_output_control[1:0] == 1, drive_output_control[4] && drive_output_control[1:0] == 0};
    mt = drive_output_control[5:4];
    if (swap_drives_i) begin
      ds = {ds[0], ds[1]};
      mt = {mt[0], mt[1]};
    end
    w = rs[4:2];
    chk("pins", {~ds, ~mt, status_mode_i == 2 || drive_output_control[3], !drive_output_control[2], pwr[0], act[1:0], w,
      w == 0 ? (act == 3 ? 3'h1 : 3'h3) : (w == 7 ? 3'h0 : w), tape_assignment[1:0], 1'b0},
      {select_out_drive1_n_o, select_out_drive0_n_o, motor_out_drive1_n_o,
      motor_out_drive0_n_o, dma_irq_gate_o, ctrl_reset_o, power_down_o, rate_field_o,
      write_field_a_o, write_field_a_steps_o, tape_drive_o, two});
  endtask
  task automatic report_and_stop;
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    #200000;
    err_count++;
    report_and_stop;
  end
  initial begin
    void'($urandom(77340));
    {rs, act, drive_output_control, pwr, tape_assignment} = {32'd2, 32'd2, 96'd0};
    fdc_config_reg_f2_i <= 8'($urandom);
    boot_drive_i <= 2'($urandom);
    repeat (3) @(posedge clk_i);
    rst_n_i <= 1;
    settle;
    outs;
    rd(floppy_ctrl_pkg::OFF_DRIVE_OUT); chk("dor_rst", 0, rdv);
    chk("track_rst", 0, write_field_a_track_o);
    for (int i = 0; i < 24; i++) begin
      @(posedge clk_i);
      status_mode_i <= 2'($urandom_range(2));
      swap_drives_i <= 1'($urandom);
      drive_output_control = $urandom & 255;
      wr(floppy_ctrl_pkg::OFF_DRIVE_OUT, 8'(drive_output_control));
      settle;
      outs;
      rd(floppy_ctrl_pkg::OFF_DRIVE_OUT); chk("dor", drive_output_control, rdv);
    end
    for (int t = 0; t < 8; t++) begin
      @(posedge clk_i);
      enhanced_floppy_mode_2_i <= t[2];
      drive_output_control = (drive_output_control & 252) | (t & 3);
      v = $urandom;
      tape_assignment = t & 3;
      wr(floppy_ctrl_pkg::OFF_DRIVE_OUT, 8'(drive_output_control));
      wr(floppy_ctrl_pkg::OFF_TAPE, {v[5:0], t[1:0]});
      rd(floppy_ctrl_pkg::OFF_TAPE);
      chk("tape", t[2] ? {fdc_config_reg_f2_i[2 * t[1:0] +: 2], boot_drive_i, t[1:0]}
        : 8'(tape_assignment), t[2] ? rdv[5:0] : rdv);
    end
    for (int r = 0; r < 8; r++) begin
      v = $urandom;
      rs = {r[2:0], v[1:0]};
      act = rs & 3;
      wr(floppy_ctrl_pkg::OFF_RATE, 8'(rs));
      settle;
      outs;
      @(posedge clk_i);
      ccr_rate_wr_i <= 1;
      ccr_rate_i <= ~v[1:0];
      @(posedge clk_i);
      ccr_rate_wr_i <= 0;
      act = 3 - v[1:0];
      settle;
      outs;
    end
    act = rs & 3;
    // Release the held reset first, or it would end the power-down at once
    drive_output_control = drive_output_control | 4;
    wr(floppy_ctrl_pkg::OFF_DRIVE_OUT, 8'(drive_output_control));
    wr(floppy_ctrl_pkg::OFF_RATE, 8'(rs | 64)); settle; pwr = 1; outs;
    rd(floppy_ctrl_pkg::OFF_RATE); chk("rate_rd", 0, rdv);
    settle; pwr = 0; outs;
    wr(floppy_ctrl_pkg::OFF_RATE, 8'(rs | 64));
    wr(floppy_ctrl_pkg::OFF_DATA, 8'h00);
    settle;
    outs;
    // Power down again so that only the self-clearing reset can wake it
    wr(floppy_ctrl_pkg::OFF_RATE, 8'(rs | 64));
    wr(floppy_ctrl_pkg::OFF_RATE, 8'(rs | 128));
    repeat (2) @(posedge clk_i); #1 chk("sw_rst", 1, ctrl_reset_o);
    repeat (3) @(posedge clk_i); #1 outs;
    rd(floppy_ctrl_pkg::OFF_TAPE); chk("tape_keep", tape_assignment, rdv[1:0]);
    @(posedge clk_i);
    addr_i <= floppy_ctrl_pkg::OFF_DRIVE_OUT;
    wdata_i <= 8'(drive_output_control & 251);
    wr_i <= 1;
    @(posedge clk_i);
    wdata_i <= 8'(drive_output_control);
    @(posedge clk_i);
    wr_i <= 0;
    #1 chk("toggle", 1, ctrl_reset_o);
    wr(10'h3f6, 8'hff); settle; outs;
    rd(floppy_ctrl_pkg::OFF_DRIVE_OUT); chk("dor_keep", drive_output_control, rdv);
    v = $urandom;
    @(posedge clk_i);
    write_field_a_track_wr_i <= 1;
    write_field_a_track_i <= v[7:0];
    swap_drives_i <= 0;
    @(posedge clk_i);
    write_field_a_track_wr_i <= 0;
    settle; chk("track", v[7:0], write_field_a_track_o);
    drive_output_control = 28;
    wr(floppy_ctrl_pkg::OFF_DRIVE_OUT, 8'(drive_output_control));
    repeat (8) @(posedge clk_i); #1 chk("spin", 1, rdy);
    report_and_stop;
  end
endmodule
`default_nettype wire
